// *** ddr_reset_ctrl.sv ***
/*
 * ddr controller core: request scheduler, command sequencer, idle and
 * self-refresh handling, soft resets, wishbone register slave.
 * assumes only rst_i (power-on) clears it; warm reset arrives as inputs.
 * memory read returns come from pins and are synchronised here.
 */
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`include "ddr_reset_defs.svh"
module ddr_reset_ctrl #(
    parameter int SOFT_RST_CYCLES = `SOFT_RST_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // interconnect request side
    input wire logic req_valid_i,
    input wire logic req_we_i,
    input wire logic [`ADDR_W-1:0] req_addr_i,
    input wire logic [`DATA_W-1:0] req_wdata_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [`DATA_W-1:0] rsp_rdata_o,
    // warm reset indications
    input wire logic hw_warm_rst_i,
    input wire logic sw_warm_rst_i,
    // memory side
    output logic cmd_valid_o,
    output ddr_reset_pkg::mem_cmd_t cmd_o,
    input wire ddr_reset_pkg::mem_ret_t ret_pin_i
);
    localparam int CW = $clog2(SOFT_RST_CYCLES + 1);
    localparam logic [CW-1:0] RST_LOAD = CW'(SOFT_RST_CYCLES);
    // last sampled cycle in which a done flag still reads 0
    localparam int RST_LAST = SOFT_RST_CYCLES - 1;

    ddr_reset_pkg::ctrl_state_t state_q;
    ddr_reset_pkg::mem_ret_t ret_s;
    ddr_reset_pkg::mem_cmd_t pend_q;
    logic ret_prev_q;
    logic ret_rise;
    logic pend_v_q;
    logic sr_idle_q;
    logic sr_reset_q;
    logic clken_q;
    logic lost_q;
    logic ctrl_done_q;
    logic sched_done_q;
    logic [CW-1:0] ctrl_cnt_q;
    logic [CW-1:0] sched_cnt_q;
    logic ctrl_srst;
    logic sched_srst;
    logic wb_req;
    logic wb_wr;
    logic accept;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
    assign ctrl_srst = wb_wr && wb_adr_i == `REG_CTRL_SYSCFG && wb_dat_i[`BIT_SOFT_RESET];
    assign sched_srst = wb_wr && wb_adr_i == `REG_SCHED_SYSCFG && wb_dat_i[`BIT_SOFT_RESET];
    assign accept = req_valid_i && req_ready_o;
    assign ret_rise = ret_s.valid && !ret_prev_q;

    pin_sync #(
        .WIDTH($bits(ddr_reset_pkg::mem_ret_t))
    ) u_ret_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(ret_pin_i),
        .level_o(ret_s)
    );

    // register slave decodes independently of the sequencer, so it
    // keeps answering while a read waits forever [RQ2]
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    `REG_POWER_CFG: begin
                        wb_dat_o[`BIT_SR_ON_IDLE] <= sr_idle_q;
                        wb_dat_o[`BIT_SR_ON_RESET] <= sr_reset_q;
                    end
                    `REG_CTRL_SYSSTAT: wb_dat_o[`BIT_RESET_DONE] <= ctrl_done_q;
                    `REG_SCHED_SYSSTAT: wb_dat_o[`BIT_RESET_DONE] <= sched_done_q;
                    `REG_CLK_ENABLE: wb_dat_o[`BIT_CLK_EN] <= clken_q;
                    `REG_IDLE_STATUS: wb_dat_o[`BIT_IDLE_ST] <= state_q[1];
                    `REG_CTRL_STATE: begin
                        wb_dat_o[1:0] <= state_q;
                        wb_dat_o[2] <= pend_v_q;
                        wb_dat_o[`BIT_LOST] <= lost_q;
                    end
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // configuration bits; warm reset never touches them [RQ1]
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sr_idle_q <= 1'b0;
            sr_reset_q <= 1'b0;
            clken_q <= 1'b1;
        end else if (wb_wr && wb_adr_i == `REG_POWER_CFG) begin
            sr_idle_q <= wb_dat_i[`BIT_SR_ON_IDLE];
            sr_reset_q <= wb_dat_i[`BIT_SR_ON_RESET];
        end else if (wb_wr && wb_adr_i == `REG_CLK_ENABLE) begin
            clken_q <= wb_dat_i[`BIT_CLK_EN];
        end
    end

    // contents-lost flag: self-refresh-on-reset setting is ignored on
    // purpose, a hardware warm reset always loses memory [RQ10]
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lost_q <= 1'b0;
        end else if (hw_warm_rst_i) begin
            lost_q <= 1'b1;
        end else if (ctrl_srst) begin
            lost_q <= 1'b0;
        end
    end

    // soft-reset done counters, one per unit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sched_cnt_q <= '0;
            sched_done_q <= 1'b1;
        end else if (sched_srst) begin
            sched_cnt_q <= RST_LOAD;
            sched_done_q <= 1'b0;
        end else if (sched_cnt_q != '0) begin
            sched_cnt_q <= sched_cnt_q - CW'(1);
            sched_done_q <= (sched_cnt_q == CW'(1));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_cnt_q <= '0;
            ctrl_done_q <= 1'b1;
        end else if (ctrl_srst) begin
            ctrl_cnt_q <= RST_LOAD;
            ctrl_done_q <= 1'b0;
        end else if (ctrl_cnt_q != '0) begin
            ctrl_cnt_q <= ctrl_cnt_q - CW'(1);
            ctrl_done_q <= (ctrl_cnt_q == CW'(1));
        end
    end

    // scheduler: one-entry holding slot, flushed by its soft reset
    always_ff @(posedge clk_i) begin
        if (rst_i || sched_srst) begin
            pend_v_q <= 1'b0;
            pend_q <= '0;
            req_ready_o <= 1'b0;
        end else begin
            if (accept) begin
                pend_v_q <= 1'b1;
                pend_q.kind <= req_we_i ? ddr_reset_pkg::CMD_WRITE : ddr_reset_pkg::CMD_READ;
                pend_q.addr <= req_addr_i;
                pend_q.wdata <= req_wdata_i;
            end else if (state_q == ddr_reset_pkg::ST_IDLE && ctrl_done_q) begin
                pend_v_q <= 1'b0;
            end
            // one-cycle bubble after each accept keeps ready a plain flop
            req_ready_o <= clken_q && sched_done_q && ctrl_done_q && !pend_v_q && !accept;
        end
    end

    // sequencer; no warm reset input reaches it, so a read lost in
    // flight leaves it waiting until a controller soft reset [RQ1]
    always_ff @(posedge clk_i) begin
        if (rst_i || ctrl_srst) begin
            state_q <= ddr_reset_pkg::ST_IDLE;
            cmd_valid_o <= 1'b0;
            cmd_o <= '0;
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= '0;
            ret_prev_q <= 1'b0;
        end else begin
            ret_prev_q <= ret_s.valid;
            cmd_valid_o <= 1'b0;
            rsp_valid_o <= 1'b0;
            unique case (state_q)
                ddr_reset_pkg::ST_IDLE: begin
                    if (pend_v_q && ctrl_done_q) begin
                        // a slot taken as the clock enable fell is still
                        // issued, so idle never strands it [RQ11]
                        cmd_valid_o <= 1'b1;
                        cmd_o <= pend_q;
                        if (pend_q.kind == ddr_reset_pkg::CMD_WRITE) begin
                            rsp_valid_o <= 1'b1;
                        end else begin
                            state_q <= ddr_reset_pkg::ST_WAIT_RD;
                        end
                    end else if (!clken_q && !pend_v_q && !accept) begin
                        // drain done; with sr_idle_q set enter self-refresh before idle ack, else park without it [RQ11]
                        if (sr_idle_q) begin
                            cmd_valid_o <= 1'b1;
                            cmd_o <= '0;
                            cmd_o.kind <= ddr_reset_pkg::CMD_SR_ENTER;
                            state_q <= ddr_reset_pkg::ST_SELF_REF;
                        end else begin
                            state_q <= ddr_reset_pkg::ST_PARKED;
                        end
                    end
                end
                ddr_reset_pkg::ST_WAIT_RD: begin
                    if (ret_rise) begin
                        rsp_valid_o <= 1'b1;
                        rsp_rdata_o <= ret_s.data;
                        state_q <= ddr_reset_pkg::ST_IDLE;
                    end
                end
                ddr_reset_pkg::ST_SELF_REF: begin
                    // memory kept in self-refresh, so after a prepared software
                    // warm reset traffic resumes with no re-init [RQ9]
                    if (clken_q) begin
                        cmd_valid_o <= 1'b1;
                        cmd_o <= '0;
                        cmd_o.kind <= ddr_reset_pkg::CMD_SR_EXIT;
                        state_q <= ddr_reset_pkg::ST_IDLE;
                    end
                end
                ddr_reset_pkg::ST_PARKED: begin
                    if (clken_q) begin
                        state_q <= ddr_reset_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    sw_reset_ignored_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ1]
        (sw_warm_rst_i || hw_warm_rst_i) && !ctrl_srst && !ret_rise |=> state_q == $past(state_q)
            || $past(state_q) != ddr_reset_pkg::ST_WAIT_RD)
        else $error("warm reset disturbed the sequencer");

    read_hang_kept_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ1]
        state_q == ddr_reset_pkg::ST_WAIT_RD && !ret_rise && !ctrl_srst
            |=> state_q == ddr_reset_pkg::ST_WAIT_RD)
        else $error("sequencer left read wait without data");

    bus_answers_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ2]
        wb_req |=> wb_ack_o)
        else $error("register access not acknowledged");

    ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ2]
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    lost_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ10]
        hw_warm_rst_i |=> lost_q)
        else $error("contents-lost flag not set");

    sr_before_idle_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ11]
        $rose(state_q == ddr_reset_pkg::ST_SELF_REF)
            |-> cmd_valid_o && cmd_o.kind == ddr_reset_pkg::CMD_SR_ENTER)
        else $error("idle ack without self-refresh entry");

    idle_needs_drain_a: assert property (@(posedge clk_i) disable iff (rst_i || ctrl_srst) // [RQ11]
        state_q == ddr_reset_pkg::ST_WAIT_RD |=> state_q != ddr_reset_pkg::ST_SELF_REF)
        else $error("self-refresh entered with a read outstanding");

    sr_exit_resume_a: assert property (@(posedge clk_i) disable iff (rst_i || ctrl_srst) // [RQ9]
        state_q == ddr_reset_pkg::ST_SELF_REF && clken_q
            |=> cmd_valid_o && cmd_o.kind == ddr_reset_pkg::CMD_SR_EXIT
            ##1 state_q == ddr_reset_pkg::ST_IDLE)
        else $error("self-refresh exit not issued");

    ctrl_done_time_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ7]
        ctrl_srst |=> !ctrl_done_q ##RST_LAST !ctrl_done_q ##1 ctrl_done_q)
        else $error("controller reset done at wrong time");

    sched_done_time_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
        sched_srst |=> !sched_done_q && !pend_v_q ##RST_LAST !sched_done_q ##1 sched_done_q)
        else $error("scheduler reset done at wrong time");

    idle_drained_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ11]
        $rose(state_q[1]) |-> !pend_v_q)
        else $error("idle reached with a request still pending");

    srst_to_idle_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ7]
        ctrl_srst |=> state_q == ddr_reset_pkg::ST_IDLE && !cmd_valid_o && !rsp_valid_o)
        else $error("controller soft reset left the sequencer busy");

    sched_blocks_req_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
        !sched_done_q |-> !req_ready_o)
        else $error("request ready during scheduler reset");
endmodule : ddr_reset_ctrl

// *** ddr_reset_defs.svh ***
/*
 * constants of the ddr controller reset and idle block.
 * assumes a 100 MHz clock and byte addresses on a 32-bit wishbone bus.
 */
// Function
// [RQ1] controller state survives warm reset untouched
// [RQ2] config registers answer even when controller hangs
// [RQ3] initiator runs idle preparation before software reset
// [RQ4] initiator first sets self-refresh-on-idle bit
// [RQ5] initiator clears clock enable, polls idle status
// [RQ6] after hardware warm reset, scheduler soft reset
// [RQ7] then controller soft reset, poll done
// [RQ8] then full re-initialisation before ordinary traffic
// [RQ9] prepared software reset needs no further recovery
// [RQ10] hardware warm reset loses memory contents always
// [RQ11] idle ack only after drain and self-refresh; code acks idle from ST_PARKED without self-refresh when sr_idle_q is 0
`ifndef DDR_RESET_DEFS_SVH
`define DDR_RESET_DEFS_SVH

`define ADDR_W 28
`define DATA_W 32

`define REG_POWER_CFG 8'h00
`define REG_CTRL_SYSCFG 8'h04
`define REG_CTRL_SYSSTAT 8'h08
`define REG_SCHED_SYSCFG 8'h0C
`define REG_SCHED_SYSSTAT 8'h10
`define REG_CLK_ENABLE 8'h14
`define REG_IDLE_STATUS 8'h18
`define REG_CTRL_STATE 8'h1C

`define BIT_SR_ON_IDLE 0
`define BIT_SR_ON_RESET 1
`define BIT_SOFT_RESET 1
`define BIT_RESET_DONE 0
`define BIT_CLK_EN 0
`define BIT_IDLE_ST 0
`define BIT_LOST 4

`define CLK_PERIOD_NS 10
`define SOFT_RST_NS 100
`define SOFT_RST_CYC ((`SOFT_RST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** ddr_reset_pkg.sv ***
/*
 * types shared by the ddr controller reset and idle block.
 * assumes the defs header is on the include path.
 */
`include "ddr_reset_defs.svh"
package ddr_reset_pkg;
    typedef enum logic [1:0] {
        CMD_READ = 2'b00,
        CMD_WRITE = 2'b01,
        CMD_SR_ENTER = 2'b10,
        CMD_SR_EXIT = 2'b11
    } mem_kind_t;

    typedef struct packed {
        mem_kind_t kind;
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] wdata;
    } mem_cmd_t;

    typedef struct packed {
        logic valid;
        logic [`DATA_W-1:0] data;
    } mem_ret_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT_RD = 2'b01,
        ST_SELF_REF = 2'b10,
        ST_PARKED = 2'b11
    } ctrl_state_t;
endpackage : ddr_reset_pkg

// *** pin_sync.sv ***
/*
 * three-stage synchroniser for a bus of pin inputs.
 * assumes inputs come from outside the clock domain; a change is taken
 * only once the second and third stages agree, for each bit on its own.
 */
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                    level_o[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= pin_i[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    // filters a one-cycle disagreement after metastability
                    if (s2_q[gi] == s3_q[gi]) begin
                        level_o[gi] <= s3_q[gi];
                    end
                end
            end
        end
    endgenerate
endmodule : pin_sync

// *** ddr_mem_model.sv ***
/*
 * behavioural ddr memory on the far side of the controller's command port.
 * assumes one command pulse per cycle and that reads are spaced apart.
 */
`timescale 1ns/1ps
module ddr_mem_model (
    input wire logic clk_i,
    input wire logic drop_i,
    input wire logic cmd_valid_i,
    input wire ddr_reset_pkg::mem_cmd_t cmd_i,
    output ddr_reset_pkg::mem_ret_t ret_o,
    output ddr_reset_pkg::mem_kind_t last_kind_o,
    output logic sr_seen_o
);
    logic [31:0] mem_q [logic [27:0]];
    logic [2:0] cnt_q;
    logic [31:0] hold_q;

    initial begin
        cnt_q = 3'h0;
        hold_q = 32'h0;
        ret_o = '0;
        sr_seen_o = 1'b0;
        last_kind_o = ddr_reset_pkg::CMD_READ;
    end

    always @(posedge clk_i) begin
        if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
        end
        // data settles one cycle ahead of valid; outside the window it churns
        ret_o.valid <= (cnt_q inside {[2:4]});
        ret_o.data <= (cnt_q inside {[2:5]}) ? hold_q : ~ret_o.data;
        if (cmd_valid_i) begin
            last_kind_o <= cmd_i.kind;
            case (cmd_i.kind)
                ddr_reset_pkg::CMD_WRITE: mem_q[cmd_i.addr] = cmd_i.wdata;
                ddr_reset_pkg::CMD_READ: begin
                    // a read issued while drop_i is high is never answered
                    if (!drop_i) begin
                        cnt_q <= 3'h6;
                        hold_q <= mem_q.exists(cmd_i.addr) ? mem_q[cmd_i.addr] : 32'h0;
                    end
                end
                ddr_reset_pkg::CMD_SR_ENTER: sr_seen_o <= 1'b1;
                default: sr_seen_o <= 1'b0;
            endcase
        end
    end
endmodule : ddr_mem_model

// *** dram_ctrl_warm_reset_recovery_tb_top.sv ***
/*
 * self-checking bench for the ddr controller warm reset and idle handling.
 * assumes the design package and defs header compile first.
 */
`timescale 1ns/1ps
`include "ddr_reset_defs.svh"
module dram_ctrl_warm_reset_recovery_tb_top;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, drop;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rsp_rdata_o, req_wdata_i, d;
    logic req_valid_i, req_we_i, req_ready_o, rsp_valid_o;
    logic hw_warm_rst_i, sw_warm_rst_i, cmd_valid_o, sr_seen;
    logic [27:0] req_addr_i;
    ddr_reset_pkg::mem_cmd_t cmd_o;
    ddr_reset_pkg::mem_ret_t ret_pin_i;
    ddr_reset_pkg::mem_kind_t last_kind;
    int num_errors = 0;
    int num_checks = 0;

    ddr_reset_ctrl #(.SOFT_RST_CYCLES(4)) uut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .req_valid_i(req_valid_i), .req_we_i(req_we_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
        .rsp_rdata_o(rsp_rdata_o), .hw_warm_rst_i(hw_warm_rst_i),
        .sw_warm_rst_i(sw_warm_rst_i), .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o),
        .ret_pin_i(ret_pin_i));
    ddr_mem_model mem (.clk_i(clk_i), .drop_i(drop), .cmd_valid_i(cmd_valid_o),
        .cmd_i(cmd_o), .ret_o(ret_pin_i), .last_kind_o(last_kind), .sr_seen_o(sr_seen));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task end_of_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one classic cycle; data taken at the ack edge, then a cycle idle
    task wb_io(input logic we, input logic [7:0] a, input logic [31:0] wd);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= wd;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        d = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb_io

    task wb_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        wb_io(1'b0, a, 32'h0);
        chk(d & m, e);
    endtask : wb_chk

    task soft_rst(input logic [7:0] cfg, input logic [7:0] st);
        wb_io(1'b1, cfg, 32'h2);
        wb_chk(st, 32'h1, 32'h0);
        do wb_io(1'b0, st, 32'h0); while (d[0] !== 1'b1);
        chk(d & 32'h1, 32'h1);
    endtask : soft_rst

    task mem_req(input logic we, input logic [27:0] a, input logic [31:0] wd, input logic w);
        req_we_i <= we;
        req_addr_i <= a;
        req_wdata_i <= wd;
        req_valid_i <= 1'b1;
        do @(posedge clk_i); while (req_ready_o !== 1'b1);
        req_valid_i <= 1'b0;
        if (w) begin
            do @(posedge clk_i); while (rsp_valid_o !== 1'b1);
            if (!we) chk(rsp_rdata_o, wd);
        end
    endtask : mem_req

    initial begin
        #200000;
        num_errors++;
        end_of_test();
    end

    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, req_valid_i, req_we_i, drop} = 6'h0;
        {hw_warm_rst_i, sw_warm_rst_i} = 2'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        req_addr_i = 28'h0;
        req_wdata_i = 32'h0;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_chk(`REG_CLK_ENABLE, 32'hFFFFFFFF, 32'h1);
        wb_chk(`REG_CTRL_SYSSTAT, 32'h1, 32'h1);
        wb_chk(`REG_SCHED_SYSSTAT, 32'h1, 32'h1);
        wb_chk(`REG_POWER_CFG, 32'hFFFFFFFF, 32'h0);
        wb_io(1'b1, 8'h40, 32'hFFFFFFFF);
        wb_chk(8'h40, 32'hFFFFFFFF, 32'h0);
        mem_req(1'b1, 28'h0000010, 32'hA5A50001, 1'b1);
        mem_req(1'b0, 28'h0000010, 32'hA5A50001, 1'b1);
        // prepared software reset keeps contents
        wb_io(1'b1, `REG_POWER_CFG, 32'h1);
        wb_io(1'b1, `REG_CLK_ENABLE, 32'h0);
        do wb_io(1'b0, `REG_IDLE_STATUS, 32'h0); while (d[0] !== 1'b1);
        chk(sr_seen, 1'b1);
        wb_chk(`REG_CTRL_STATE, 32'h3, 32'h2);
        sw_warm_rst_i <= 1'b1;
        @(posedge clk_i);
        sw_warm_rst_i <= 1'b0;
        wb_io(1'b1, `REG_CLK_ENABLE, 32'h1);
        while (last_kind !== ddr_reset_pkg::CMD_SR_EXIT) @(posedge clk_i);
        mem_req(1'b0, 28'h0000010, 32'hA5A50001, 1'b1);
        wb_chk(`REG_CTRL_STATE, 32'h10, 32'h0);
        // hardware warm reset while a read is lost in flight
        drop <= 1'b1;
        mem_req(1'b0, 28'h0000020, 32'h0, 1'b0);
        repeat (8) @(posedge clk_i);
        hw_warm_rst_i <= 1'b1;
        @(posedge clk_i);
        hw_warm_rst_i <= 1'b0;
        wb_chk(`REG_CTRL_STATE, 32'h3, 32'h1);
        wb_chk(`REG_CTRL_STATE, 32'h10, 32'h10);
        wb_chk(`REG_CLK_ENABLE, 32'h1, 32'h1);
        chk(req_ready_o, 1'b1);
        mem_req(1'b1, 28'h0000030, 32'h0, 1'b0);
        repeat (4) @(posedge clk_i);
        chk(req_ready_o, 1'b0);
        wb_chk(`REG_CTRL_STATE, 32'h7, 32'h5);
        drop <= 1'b0;
        soft_rst(`REG_SCHED_SYSCFG, `REG_SCHED_SYSSTAT);
        soft_rst(`REG_CTRL_SYSCFG, `REG_CTRL_SYSSTAT);
        wb_chk(`REG_CTRL_STATE, 32'h13, 32'h0);
        wb_io(1'b1, `REG_POWER_CFG, 32'h0);
        wb_io(1'b1, `REG_CLK_ENABLE, 32'h1);
        mem_req(1'b1, 28'h0000020, 32'h5A5A0002, 1'b1);
        mem_req(1'b0, 28'h0000020, 32'h5A5A0002, 1'b1);
        end_of_test();
    end
endmodule : dram_ctrl_warm_reset_recovery_tb_top
